// ===== bench/egip_loop_model.sv
`timescale 1ns/1ns
`default_nettype none
module egip_loop_model (
	input  wire logic        mclk,       // Clock
	input  wire logic        reset,      // Sync reset
	input  wire logic        fire,       // Request one cycle
	input  wire logic [31:0] droopSet,   // Droop to present
	output var  logic        ctrlTick,   // Control strobe
	output var  logic [31:0] droopCount  // Held droop
);
	// Droop held between ticks, as a servo loop latch would
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrlTick <= 1'b0;
			droopCount <= 32'h0;
		end else begin
			ctrlTick <= fire;
			if (fire)
				droopCount <= droopSet;
		end
	end
endmodule // egip_loop_model
`default_nettype wire

// ===== bench/egip_props_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "egip_consts.vh"
module egip_props (
	input wire logic        mclk,           // Clock
	input wire logic        reset,          // Sync reset
	input wire logic        wb_cyc_i,       // Cycle
	input wire logic        wb_stb_i,       // Strobe
	input wire logic        wb_we_i,        // Write
	input wire logic [7:0]  wb_adr_i,       // Address
	input wire logic [3:0]  wb_sel_i,       // Lanes
	input wire logic [31:0] wb_dat_i,       // Write data
	input wire logic        wb_ack_o,       // Ack
	input wire logic        ctrlTick,       // Tick
	input wire logic [1:0]  ctrlMode,       // Mode
	input wire logic        inPositionFlag, // Flag
	input wire logic        scaledValid,    // Result pulse
	input wire logic        paramAlarm,     // Alarm
	input wire logic [7:0]  alarmCode       // Alarm code
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	wire logic reqNew = wb_cyc_i && wb_stb_i && !wb_ack_o;
	property p_ack_next; reqNew |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_mode_off; ctrlMode != `EGIP_MODE_POSITION |=> !inPositionFlag; endproperty
	a_mode_off: assert property (p_mode_off) else $error("flag in off mode");
	property p_flag_hold;
		!ctrlTick && ctrlMode == `EGIP_MODE_POSITION |=> $stable(inPositionFlag);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag moved off tick");
	property p_alarm_code; alarmCode == (paramAlarm ? `EGIP_ALARM_PARAM : 8'h00); endproperty
	a_alarm_code: assert property (p_alarm_code) else $error("bad alarm code");
	property p_num_limit;
		reqNew && wb_we_i && wb_adr_i == `EGIP_OFF_GEAR_NUM && wb_sel_i == 4'hF
			&& wb_dat_i > `EGIP_NUM_MAX |=> paramAlarm;
	endproperty
	a_num_limit: assert property (p_num_limit) else $error("big numerator accepted");
	property p_alarm_sticky;
		paramAlarm && !(reqNew && wb_we_i && wb_adr_i == `EGIP_OFF_STATUS) |=> paramAlarm;
	endproperty
	a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm lost");
	property p_valid_pulse; scaledValid |=> !scaledValid; endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
	c_flag: cover property (ctrlTick ##1 inPositionFlag);
	c_valid: cover property (scaledValid);
	c_alarm: cover property ($rose(paramAlarm));
endmodule // egip_props
bind egip_top egip_props egip_props_i (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .ctrlTick, .ctrlMode, .inPositionFlag,
	.scaledValid, .paramAlarm, .alarmCode);
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "egip_consts.vh"
module tb_top;
	logic        mclk = 1'b0, reset = 1'b1, cyc = 1'b0, we = 1'b0, fire = 1'b0;
	logic        done = 1'b0, start = 1'b0;
	logic [1:0]  mode = 2'h0;
	logic [7:0]  adr = 8'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] datW = 32'h0, droopSet = 32'h0, cmdIn = 32'h0, fbIn = 32'h0, junk;
	wire  logic [31:0] datR, droop, sCmd, sFb;
	wire  logic [7:0]  aCode;
	wire  logic [1:0]  pUnit;
	wire  logic        ack, tick, flag, sValid, alarm, rUnit;
	int          n_fail = 0, comparisons = 0, cycles = 0, i;
	always #20 mclk = ~mclk;
	egip_loop_model egip_loop_model_i (.mclk(mclk), .reset(reset), .fire(fire),
		.droopSet(droopSet), .ctrlTick(tick), .droopCount(droop));
	egip_top egip_top_i (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
		.wb_ack_o(ack), .ctrlTick(tick), .ctrlMode(mode), .cmdDone(done),
		.startActive(start), .droopCount(droop), .cmdIn(cmdIn), .fbIn(fbIn),
		.inPositionFlag(flag), .scaledCmd(sCmd), .scaledFb(sFb), .scaledValid(sValid),
		.paramAlarm(alarm), .alarmCode(aCode), .positionUnit(pUnit), .rangeUnit(rUnit));
	task automatic wrap_up;
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until ack is sampled, then released
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		sel <= 4'hF;
		do @(posedge mclk); while (ack !== 1'b1);
		junk = datR;
		cyc <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(junk, exp);
	endtask
	task automatic tk(input logic [31:0] dr, input logic expF);
		@(posedge mclk);
		droopSet <= dr;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({31'h0, flag}, {31'h0, expF});
	endtask
	task automatic s_reset;
		rd(`EGIP_OFF_GEAR_NUM, 32'h1);
		rd(`EGIP_OFF_INP_RANGE, 32'h640);
		rd(`EGIP_OFF_CONFIG, 32'h300);
		chk({29'h0, pUnit, rUnit}, 32'h6);
	endtask
	task automatic s_range;
		wr(`EGIP_OFF_CONFIG, 32'h00000301);
		tk(32'h00000640, 1'b1);
		tk(32'h00000641, 1'b0);
		tk(32'hFFFFF9C0, 1'b1);
		tk(32'hFFFFF9BF, 1'b0);
		for (int oc = 0; oc < 3; oc++)
			for (int c = 0; c < 4; c++) begin
				wr(`EGIP_OFF_CONFIG, 32'h00000301 | (oc << 4));
				done <= c[0];
				start <= c[1];
				tk(32'h00000005, oc == 0 || (c[0] && (oc == 1 || !c[1])));
			end
		wr(`EGIP_OFF_CONFIG, 32'h00000301);
		tk(32'h00000005, 1'b1);
		mode <= 2'h1;
		repeat (2) @(posedge mclk);
		chk({31'h0, flag}, 32'h0);
		for (int m = 1; m < 4; m++) begin
			mode <= m[1:0];
			tk(32'h00000005, 1'b0);
		end
		mode <= 2'h0;
	endtask
	task automatic s_gear;
		wr(`EGIP_OFF_OD_SELECT, 32'h00609101);
		wr(`EGIP_OFF_OD_DATA, 32'h00000006);
		wr(`EGIP_OFF_OD_SELECT, 32'h00609102);
		wr(`EGIP_OFF_OD_DATA, 32'h00000003);
		rd(`EGIP_OFF_GEAR_NUM, 32'h00000006);
		rd(`EGIP_OFF_OD_DATA, 32'h00000003);
		wr(`EGIP_OFF_CONFIG, 32'h00000300);
		tk(32'h00000C80, 1'b1);
		tk(32'h00000C81, 1'b0);
		wr(`EGIP_OFF_GEAR_NUM, 32'h80000000);
		rd(`EGIP_OFF_GEAR_NUM, 32'h00000006);
		chk({23'h0, alarm, aCode}, 32'h00000137);
		wr(`EGIP_OFF_STATUS, 32'h00000002);
		chk({31'h0, alarm}, 32'h0);
		wr(`EGIP_OFF_GEAR_NUM, 32'h7FFFFFFF);
		rd(`EGIP_OFF_GEAR_NUM, 32'h7FFFFFFF);
		chk({31'h0, alarm}, 32'h0);
		// Ball screw in mm: travel scaled by 1000, ratio reduced to whole numbers
		wr(`EGIP_OFF_GEAR_NUM, 32'h00200000);
		wr(`EGIP_OFF_GEAR_DEN, 32'h00000271);
		rd(`EGIP_OFF_GEAR_DEN, 32'h00000271);
		rd(8'h1C, 32'h0);
	endtask
	task automatic s_scale;
		repeat (140) @(posedge mclk);
		wr(`EGIP_OFF_CONFIG, 32'h00000200);
		wr(`EGIP_OFF_GEAR_NUM, 32'h00000019);
		wr(`EGIP_OFF_GEAR_DEN, 32'h0000000B);
		cmdIn <= 32'h00000064;
		fbIn <= 32'hFFFFFFF9;
		tk(32'h00000000, 1'b1);
		for (i = 0; i < 200 && sValid !== 1'b1; i++)
			@(posedge mclk);
		chk({31'h0, sValid}, 32'h00000001);
		chk(sCmd, 32'h000000E3);
		chk(sFb, 32'hFFFFFFFD);
		chk({30'h0, pUnit}, 32'h2);
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		s_reset();
		s_range();
		s_gear();
		s_scale();
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire

// ===== rtl/egip_consts.vh
`ifndef EGIP_CONSTS_VH
`define EGIP_CONSTS_VH

// Register byte offsets
`define EGIP_OFF_GEAR_NUM   8'h00
`define EGIP_OFF_GEAR_DEN   8'h04
`define EGIP_OFF_INP_RANGE  8'h08
`define EGIP_OFF_CONFIG     8'h0C
`define EGIP_OFF_STATUS     8'h10
`define EGIP_OFF_OD_SELECT  8'h14
`define EGIP_OFF_OD_DATA    8'h18

// Reset values
`define EGIP_RST_GEAR_NUM   32'h00000001
`define EGIP_RST_GEAR_DEN   32'h00000001
`define EGIP_RST_INP_RANGE  32'h00000640
`define EGIP_RST_RANGE_UNIT 1'b0
`define EGIP_RST_ON_COND    2'h0
`define EGIP_RST_POS_UNIT   2'h3

// CONFIG fields
`define EGIP_CFG_RANGE_UNIT 0
`define EGIP_CFG_ON_COND_LO 4
`define EGIP_CFG_ON_COND_HI 5
`define EGIP_CFG_POS_UNIT_LO 8
`define EGIP_CFG_POS_UNIT_HI 9

// STATUS fields
`define EGIP_STS_INP        0
`define EGIP_STS_ALARM      1
`define EGIP_STS_BUSY       2

// On-condition and unit codes
`define EGIP_ON_RANGE       2'h0
`define EGIP_ON_RANGE_DONE  2'h1
`define EGIP_ON_RANGE_STOP  2'h2
`define EGIP_MODE_POSITION  2'h0
`define EGIP_UNIT_DEGREE    2'h2
`define EGIP_UNIT_PULSE     2'h3

// Object dictionary mapping
`define EGIP_OD_GEAR_INDEX  16'h6091
`define EGIP_OD_SUB_NUM     8'h01
`define EGIP_OD_SUB_DEN     8'h02

// Alarm and limits
`define EGIP_ALARM_PARAM    8'h37
`define EGIP_NUM_MAX        32'h7FFFFFFF
`define EGIP_DIV_STEPS      7'h40

`endif

// ===== rtl/egip_top.v
// Operation
// - Flag in-position when droop magnitude is at or below the range.
// - Flag stays off in velocity, torque and continuous-to-torque modes.
// - In-position range resets to 1600 pulses, tuned for 22-bit encoders.
// - Range unit select: 0 command pulses (default), 1 encoder pulses.
// - On-condition 0 (default): in range alone sets the flag.
// - On-condition 1: in range and command output completed.
// - On-condition 2: also requires the start signal to be off.
// - Pulse unit: numerator over denominator equals encoder pulses per travel.
// - Degree unit: numerator machine teeth, denominator motor teeth.
// - Gear values also writable via object 6091h sub 01h and 02h.
// - Command times gear ratio, feedback times its reciprocal.
// - Out-of-range gear setting raises parameter alarm 037.
// - Numerator above 2147483647 is out of range.
`timescale 1ns/1ns
`default_nettype none
`include "egip_consts.vh"

module egip_top (
	input  wire        mclk,          // 25 MHz clock
	input  wire        reset,         // Sync reset, high
	input  wire        wb_cyc_i,      // Wishbone cycle
	input  wire        wb_stb_i,      // Wishbone strobe
	input  wire        wb_we_i,       // Write enable
	input  wire [7:0]  wb_adr_i,      // Byte address
	input  wire [3:0]  wb_sel_i,      // Byte lanes
	input  wire [31:0] wb_dat_i,      // Write data
	output reg  [31:0] wb_dat_o,      // Read data
	output reg         wb_ack_o,      // Acknowledge
	input  wire        ctrlTick,      // Control cycle strobe
	input  wire [1:0]  ctrlMode,      // 0 position, else off
	input  wire        cmdDone,       // Command output completed
	input  wire        startActive,   // Start signal on
	input  wire [31:0] droopCount,    // Signed droop, encoder pulses
	input  wire [31:0] cmdIn,         // Signed command delta
	input  wire [31:0] fbIn,          // Signed feedback delta
	output reg         inPositionFlag,// In-position output
	output reg  [31:0] scaledCmd,     // Command times ratio
	output reg  [31:0] scaledFb,      // Feedback over ratio
	output reg         scaledValid,   // Scaled pair ready pulse
	output reg         paramAlarm,    // Parameter alarm, sticky
	output reg  [7:0]  alarmCode,     // Alarm code when set
	output wire [1:0]  positionUnit,  // Position unit select
	output wire        rangeUnit      // Range unit select
);

	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_CMD  = 4'h2;
	localparam [3:0] ST_FB   = 4'h4;
	localparam [3:0] ST_DONE = 4'h8;

	reg [31:0] gearNumerator;
	reg [31:0] gearDenominator;
	reg [31:0] inPositionRange;
	reg        rangeUnitSelect;
	reg [1:0]  onConditionSelect;
	reg [1:0]  positionUnitSelect;
	reg [23:0] odSelect;

	reg [3:0]  state;
	reg [63:0] dividend;
	reg [32:0] remainder;
	reg [31:0] divisor;
	reg [6:0]  stepCount;
	reg        negCmd;
	reg        negFb;
	reg [31:0] fbHold;

	wire        busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        busWr = busReq & wb_we_i;
	wire [31:0] laneMask;
	wire [31:0] droopMag;
	wire [31:0] cmdMag;
	wire [31:0] fbMag;
	wire [63:0] droopScaled;
	wire [63:0] rangeScaled;
	wire        inRange;
	wire        nextFlag;
	wire        odHit;
	wire        wrNum;
	wire        wrDen;
	wire [31:0] newNum;
	wire [31:0] newDen;
	wire        badNum;
	wire        badDen;
	wire [32:0] trial;
	wire        trialFits;
	wire [31:0] newOdSel;

	// Most negative input maps to 2^31, inside a range of 2^31 or more
	function [31:0] magnitude;
		input [31:0] v;
		begin
			magnitude = v[31] ? (~v + 32'h00000001) : v;
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [31:0] mask;
		begin
			merge = (old & ~mask) | (dat & mask);
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gLane
			assign laneMask[g*8 +: 8] = {8{wb_sel_i[g]}};
		end
	endgenerate

	assign positionUnit = positionUnitSelect;
	assign rangeUnit = rangeUnitSelect;

	assign droopMag = magnitude(droopCount);
	assign cmdMag = magnitude(cmdIn);
	assign fbMag = magnitude(fbIn);

	// unit of the range
	// Cross-multiplied so no divider sits in the compare path
	assign droopScaled = rangeUnitSelect
		? {32'h00000000, droopMag}
		: {32'h00000000, droopMag} * {32'h00000000, gearDenominator};
	assign rangeScaled = rangeUnitSelect
		? {32'h00000000, inPositionRange}
		: {32'h00000000, inPositionRange} * {32'h00000000, gearNumerator};

	assign inRange = droopScaled <= rangeScaled;

	reg condMet;
	always @* begin
		case (onConditionSelect)
			`EGIP_ON_RANGE: condMet = inRange;
			`EGIP_ON_RANGE_DONE: condMet = inRange & cmdDone;
			`EGIP_ON_RANGE_STOP: condMet = inRange & cmdDone & ~startActive;
			default: condMet = inRange;
		endcase
	end

	assign nextFlag = condMet & (ctrlMode == `EGIP_MODE_POSITION);

	// Other objects read as zero and writes to them are dropped
	// object dictionary map
	assign odHit = odSelect[23:8] == `EGIP_OD_GEAR_INDEX;
	assign wrNum = busWr & ((wb_adr_i == `EGIP_OFF_GEAR_NUM)
		| ((wb_adr_i == `EGIP_OFF_OD_DATA) & odHit
		& (odSelect[7:0] == `EGIP_OD_SUB_NUM)));
	assign wrDen = busWr & ((wb_adr_i == `EGIP_OFF_GEAR_DEN)
		| ((wb_adr_i == `EGIP_OFF_OD_DATA) & odHit
		& (odSelect[7:0] == `EGIP_OD_SUB_DEN)));
	assign newNum = merge(gearNumerator, wb_dat_i, laneMask);
	assign newDen = merge(gearDenominator, wb_dat_i, laneMask);
	assign newOdSel = merge({8'h00, odSelect}, wb_dat_i, laneMask);

	// A zero gear would make the divider return all ones, so it is refused too
	// numerator ceiling
	assign badNum = wrNum & ((newNum > `EGIP_NUM_MAX) | (newNum == 32'h00000000));
	assign badDen = wrDen & (newDen == 32'h00000000);

	// Wishbone slave, one wait state
	// Write lands on the edge that samples the request, the same edge that raises ack
	always @(posedge mclk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= busReq;
			if (busReq & ~wb_we_i) begin
				case (wb_adr_i)
					`EGIP_OFF_GEAR_NUM: wb_dat_o <= gearNumerator;
					`EGIP_OFF_GEAR_DEN: wb_dat_o <= gearDenominator;
					`EGIP_OFF_INP_RANGE: wb_dat_o <= inPositionRange;
					`EGIP_OFF_CONFIG: wb_dat_o <= {22'h000000,
						positionUnitSelect, 2'h0, onConditionSelect,
						3'h0, rangeUnitSelect};
					`EGIP_OFF_STATUS: wb_dat_o <= {29'h00000000,
						state != ST_IDLE, paramAlarm, inPositionFlag};
					`EGIP_OFF_OD_SELECT: wb_dat_o <= {8'h00, odSelect};
					`EGIP_OFF_OD_DATA: begin
						if (odHit & (odSelect[7:0] == `EGIP_OD_SUB_NUM)) begin
							wb_dat_o <= gearNumerator;
						end else if (odHit & (odSelect[7:0] == `EGIP_OD_SUB_DEN)) begin
							wb_dat_o <= gearDenominator;
						end else begin
							wb_dat_o <= 32'h00000000;
						end
					end
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Settings written by software
	always @(posedge mclk) begin
		if (reset) begin
			gearNumerator <= `EGIP_RST_GEAR_NUM;
			gearDenominator <= `EGIP_RST_GEAR_DEN;
			inPositionRange <= `EGIP_RST_INP_RANGE;
			rangeUnitSelect <= `EGIP_RST_RANGE_UNIT;
			onConditionSelect <= `EGIP_RST_ON_COND;
			positionUnitSelect <= `EGIP_RST_POS_UNIT;
			odSelect <= 24'h000000;
		end else begin
			// ratio held as written
			// Rejected values leave the previous ratio in force
			if (wrNum & ~badNum) begin
				gearNumerator <= newNum;
			end
			if (wrDen & ~badDen) begin
				gearDenominator <= newDen;
			end
			if (busWr & (wb_adr_i == `EGIP_OFF_INP_RANGE)) begin
				inPositionRange <= merge(inPositionRange, wb_dat_i, laneMask);
			end
			if (busWr & (wb_adr_i == `EGIP_OFF_CONFIG) & wb_sel_i[0]) begin
				rangeUnitSelect <= wb_dat_i[`EGIP_CFG_RANGE_UNIT];
				onConditionSelect <= wb_dat_i[`EGIP_CFG_ON_COND_HI:`EGIP_CFG_ON_COND_LO];
			end
			if (busWr & (wb_adr_i == `EGIP_OFF_CONFIG) & wb_sel_i[1]) begin
				positionUnitSelect <= wb_dat_i[`EGIP_CFG_POS_UNIT_HI:`EGIP_CFG_POS_UNIT_LO];
			end
			if (busWr & (wb_adr_i == `EGIP_OFF_OD_SELECT)) begin
				odSelect <= newOdSel[23:0];
			end
		end
	end

	// parameter alarm
	// Set wins over a write-one clear in the same cycle
	// Code is registered with the flag so both change on one edge
	always @(posedge mclk) begin
		if (reset) begin
			paramAlarm <= 1'b0;
			alarmCode <= 8'h00;
		end else if (badNum | badDen) begin
			paramAlarm <= 1'b1;
			alarmCode <= `EGIP_ALARM_PARAM;
		end else if (busWr & (wb_adr_i == `EGIP_OFF_STATUS) & wb_sel_i[0]
			& wb_dat_i[`EGIP_STS_ALARM]) begin
			paramAlarm <= 1'b0;
			alarmCode <= 8'h00;
		end
	end

	// once per control cycle
	// Leaving position mode drops the flag at once, not at the next tick
	always @(posedge mclk) begin
		if (reset) begin
			inPositionFlag <= 1'b0;
		end else if (ctrlMode != `EGIP_MODE_POSITION) begin
			inPositionFlag <= 1'b0;
		end else if (ctrlTick) begin
			inPositionFlag <= nextFlag;
		end
	end

	assign trial = {remainder[31:0], dividend[63]};
	assign trialFits = trial >= {1'b0, divisor};

	// gear scaling engine
	// Shared restoring divider, 64 steps per operand
	// Ticks during a run are not scaled; results keep the low 32 bits
	always @(posedge mclk) begin
		if (reset) begin
			state <= ST_IDLE;
			dividend <= 64'h0000000000000000;
			remainder <= 33'h000000000;
			divisor <= 32'h00000000;
			stepCount <= 7'h00;
			negCmd <= 1'b0;
			negFb <= 1'b0;
			fbHold <= 32'h00000000;
			scaledCmd <= 32'h00000000;
			scaledFb <= 32'h00000000;
			scaledValid <= 1'b0;
		end else begin
			scaledValid <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (ctrlTick) begin
						dividend <= {32'h00000000, cmdMag} * {32'h00000000, gearNumerator};
						divisor <= gearDenominator;
						remainder <= 33'h000000000;
						stepCount <= `EGIP_DIV_STEPS;
						negCmd <= cmdIn[31];
						negFb <= fbIn[31];
						fbHold <= fbMag;
						state <= ST_CMD;
					end
				end
				ST_CMD: begin
					remainder <= trialFits ? (trial - {1'b0, divisor}) : trial;
					dividend <= {dividend[62:0], trialFits};
					stepCount <= stepCount - 7'h01;
					if (stepCount == 7'h01) begin
						state <= ST_FB;
					end
				end
				ST_FB: begin
					if (stepCount == 7'h00) begin
						scaledCmd <= negCmd ? (~dividend[31:0] + 32'h00000001)
							: dividend[31:0];
						dividend <= {32'h00000000, fbHold} * {32'h00000000, gearDenominator};
						divisor <= gearNumerator;
						remainder <= 33'h000000000;
						stepCount <= `EGIP_DIV_STEPS + 7'h01;
					end else begin
						remainder <= trialFits ? (trial - {1'b0, divisor}) : trial;
						dividend <= {dividend[62:0], trialFits};
						stepCount <= stepCount - 7'h01;
						if (stepCount == 7'h02) begin
							state <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					scaledFb <= negFb ? (~dividend[31:0] + 32'h00000001)
						: dividend[31:0];
					scaledValid <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

endmodule // egip_top

`default_nettype wire
